// ---- ctsc_consts.svh ----
// Register map, field positions and timing constants of the trigger block
`ifndef CTSC_CONSTS_SVH
`define CTSC_CONSTS_SVH
`define CTSC_A_CTRL   8'h00
`define CTSC_A_BURST  8'h04
`define CTSC_A_DELAY  8'h08
`define CTSC_A_DEB    8'h0C
`define CTSC_A_SDUR   8'h10
`define CTSC_A_SWTRIG 8'h14
`define CTSC_A_STAT   8'h18
`define CTSC_F_MODE   0
`define CTSC_F_SRC    3:1
`define CTSC_F_ACT    6:4
`define CTSC_F_CACHE  7
`define CTSC_F_STREN  8
`define CTSC_F_INV    9
`define CTSC_F_L2OUT  10
`define CTSC_F_SSRC   14:11
`define CTSC_F_CNT    9:0
`define CTSC_F_US     19:0
`define CTSC_F_SDUR   15:0
`define CTSC_BURST_MIN 10'h001
`define CTSC_BURST_MAX 10'h3FF
`define CTSC_DEB_MAX   20'hF4240
`define CTSC_QDEPTH    2'h3
`define CTSC_CLK_NS    10
`define CTSC_NS_PER_US 1000
`define CTSC_US_CYC    (`CTSC_NS_PER_US / `CTSC_CLK_NS)
`define CTSC_RESP_OK   2'h0
`define CTSC_RESP_ERR  2'h2
`define CTSC_FULL_STRB 4'hF
`endif

// ---- ctsc_pkg.sv ----
// Types shared by the trigger and strobe block
package ctsc_pkg;
   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_DELAY = 4'b0010,
      ST_EXPO  = 4'b0100,
      ST_READ  = 4'b1000
   } ctsc_state_t;
   typedef enum logic [2:0] {
      SRC_SW = 3'h0, SRC_LINE0 = 3'h1, SRC_LINE2 = 3'h2,
      SRC_CNT = 3'h3, SRC_ANY = 3'h4
   } ctsc_src_t;
   typedef enum logic [2:0] {
      ACT_RISE = 3'h0, ACT_FALL = 3'h1, ACT_HIGH = 3'h2,
      ACT_LOW = 3'h3, ACT_ANY = 3'h4
   } ctsc_act_t;
   typedef enum logic [3:0] {
      EV_EXP_ST = 4'h0, EV_EXP_END = 4'h1, EV_ACQ_ST = 4'h2,
      EV_ACQ_STOP = 4'h3, EV_BURST_ST = 4'h4, EV_BURST_END = 4'h5,
      EV_FWAIT = 4'h6, EV_FRM_ST = 4'h7, EV_FRM_END = 4'h8,
      EV_SWTRIG = 4'h9, EV_HWTRIG = 4'hA, EV_CNTTRIG = 4'hB,
      EV_TIMER = 4'hC
   } ctsc_ev_t;
   typedef struct packed {
      logic        mode;
      ctsc_src_t   src;
      ctsc_act_t   act;
      logic        cache;
      logic        str_en;
      logic        inv;
      logic        l2_out;
      ctsc_ev_t    ssrc;
   } ctsc_cfg_t;
   typedef struct packed {
      logic       acquiring;
      logic       exposing;
      logic       frame_wait;
      logic [1:0] queued;
   } ctsc_stat_t;
endpackage : ctsc_pkg

// ---- ctsc_trigger.sv ----
// Trigger conditioning, burst sequencing and strobe output with AXI4-Lite registers
// Summary of operation
// - Frames per trigger accepted only 1..1023
// - One frame single mode, more is multi
// - Each trigger gives n exposures, then stop
// - Edge modes trigger on chosen transition only
// - Level high keeps acquiring while high
// - Level low keeps acquiring while low
// - Any edge triggers on both transitions
// - Programmable microsecond delay before trigger acts
// - Queue holds at most three pending triggers
// - Queue off drops triggers while busy
// - Queued trigger runs after current completes; one queued in its final cycle into an empty queue waits for another trigger
// - Glitch filter time 0..1000000 us
// - Pulses shorter than filter are ignored
// - Pin triggers use all trigger settings
// - Software triggers skip activation and filter
// - Counter and any-source skip the filter
// - Optional output inversion, off after reset
// - Enabled strobe follows chosen event source
// - Exposure and acquisition start/stop sources
// - Burst and frame start/end sources
// - Source showing wait for frame trigger
// - Software, hardware, counter, timer trigger sources
// - Trigger mode off acquires on internal timing
// - Any-source takes software and line 0 pin triggers
// - Zero strobe length follows exposure length
`timescale 1ns/1ps
`include "ctsc_consts.svh"
module ctsc_trigger #(
   parameter int EXPO_CYC = 16,
   parameter int READ_CYC = 16
) (
   input  wire logic                aclk,
   input  wire logic                aresetn,
   input  wire logic [7:0]          s_axi_awaddr,
   input  wire logic                s_axi_awvalid,
   output logic                     s_axi_awready,
   input  wire logic [31:0]         s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   input  wire logic                s_axi_wvalid,
   output logic                     s_axi_wready,
   output logic [1:0]               s_axi_bresp,
   output logic                     s_axi_bvalid,
   input  wire logic                s_axi_bready,
   input  wire logic [7:0]          s_axi_araddr,
   input  wire logic                s_axi_arvalid,
   output logic                     s_axi_arready,
   output logic [31:0]              s_axi_rdata,
   output logic [1:0]               s_axi_rresp,
   output logic                     s_axi_rvalid,
   input  wire logic                s_axi_rready,
   input  wire logic                line0_i,
   input  wire logic                line2_i,
   input  wire logic                counter_i,
   input  wire logic                timer_i,
   output logic                     line1_o,
   output logic                     line2_o,
   output logic                     line2_oe,
   output ctsc_pkg::ctsc_stat_t     stat_o
);
   import ctsc_pkg::*;

   initial begin
      if (EXPO_CYC < 1 || EXPO_CYC > 1048575 || READ_CYC < 1 || READ_CYC > 1048575)
         $error("ctsc_trigger: phase lengths out of range");
   end

   localparam logic [19:0] EXPO_LAST = 20'(EXPO_CYC - 1);
   localparam logic [19:0] READ_LAST = 20'(READ_CYC - 1);
   localparam logic [6:0]  US_LAST   = 7'(`CTSC_US_CYC - 1);

   ctsc_cfg_t   cfg_r;
   logic [9:0]  burst_r;
   logic [19:0] dly_us_r, deb_us_r;
   logic [15:0] sdur_r;
   logic        sw_pulse_r;
   logic        aw_ok_r, w_ok_r;
   logic [7:0]  waddr_r;
   logic [31:0] wdata_r;
   logic [3:0]  wstrb_r;
   logic        wr_fire;

   // Write channel: address and data taken in either order
   assign wr_fire = aw_ok_r && w_ok_r && !s_axi_bvalid;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `CTSC_RESP_OK;
         aw_ok_r       <= 1'b0;
         w_ok_r        <= 1'b0;
         waddr_r       <= 8'h00;
         wdata_r       <= 32'h0000_0000;
         wstrb_r       <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            aw_ok_r       <= 1'b1;
            waddr_r       <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            w_ok_r       <= 1'b1;
            wdata_r      <= s_axi_wdata;
            wstrb_r      <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_ok_r      <= 1'b0;
            w_ok_r       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (waddr_r > `CTSC_A_STAT || waddr_r[1:0] != 2'h0)
                            ? `CTSC_RESP_ERR : `CTSC_RESP_OK;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // Config registers; partial-word writes are ignored
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg_r      <= '{mode: 1'b0, src: SRC_SW, act: ACT_RISE, cache: 1'b0,
                         str_en: 1'b0, inv: 1'b0, l2_out: 1'b0, ssrc: EV_EXP_ST};
         burst_r    <= `CTSC_BURST_MIN;
         dly_us_r   <= 20'h00000;
         deb_us_r   <= 20'h00000;
         sdur_r     <= 16'h0000;
         sw_pulse_r <= 1'b0;
      end else begin
         sw_pulse_r <= 1'b0;
         if (wr_fire && wstrb_r == `CTSC_FULL_STRB) begin
            case (waddr_r)
               `CTSC_A_CTRL: begin
                  cfg_r.mode   <= wdata_r[`CTSC_F_MODE];
                  cfg_r.src    <= ctsc_src_t'(wdata_r[`CTSC_F_SRC]);
                  cfg_r.act    <= ctsc_act_t'(wdata_r[`CTSC_F_ACT]);
                  cfg_r.cache  <= wdata_r[`CTSC_F_CACHE];
                  cfg_r.str_en <= wdata_r[`CTSC_F_STREN];
                  cfg_r.inv    <= wdata_r[`CTSC_F_INV];
                  cfg_r.l2_out <= wdata_r[`CTSC_F_L2OUT];
                  cfg_r.ssrc   <= ctsc_ev_t'(wdata_r[`CTSC_F_SSRC]);
               end
               `CTSC_A_BURST: begin
                  if (wdata_r[31:10] == 22'h0 && wdata_r[`CTSC_F_CNT] != 10'h000)
                     burst_r <= wdata_r[`CTSC_F_CNT];
               end
               `CTSC_A_DELAY:  dly_us_r <= wdata_r[`CTSC_F_US];
               `CTSC_A_DEB: begin
                  if (wdata_r[31:20] == 12'h0 && wdata_r[`CTSC_F_US] <= `CTSC_DEB_MAX)
                     deb_us_r <= wdata_r[`CTSC_F_US];
               end
               `CTSC_A_SDUR:   sdur_r <= wdata_r[`CTSC_F_SDUR];
               `CTSC_A_SWTRIG: sw_pulse_r <= wdata_r[0];
               default: ;
            endcase
         end
      end
   end

   // Microsecond tick so that the strobe length needs no wide cycle count
   logic [6:0] us_cnt_r;
   logic       us_tick;
   assign us_tick = (us_cnt_r == US_LAST);
   always_ff @(posedge aclk) begin
      if (!aresetn)
         us_cnt_r <= 7'h00;
      else
         us_cnt_r <= us_tick ? 7'h00 : us_cnt_r + 7'h01;
   end

   // Glitch filter on the pin inputs only
   logic        pin_raw, deb_r;
   logic [19:0] deb_cnt_r;
   logic [6:0]  deb_sub_r;
   assign pin_raw = (cfg_r.src == SRC_LINE2) ? (line2_i && !cfg_r.l2_out) : line0_i;
   // Own sub-count restarts on each change, so a short pulse gains no free tick
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         deb_r     <= 1'b0;
         deb_cnt_r <= 20'h00000;
         deb_sub_r <= 7'h00;
      end else if (pin_raw == deb_r) begin
         deb_cnt_r <= 20'h00000;
         deb_sub_r <= 7'h00;
      end else if (deb_cnt_r >= deb_us_r) begin
         deb_r     <= pin_raw;
         deb_cnt_r <= 20'h00000;
         deb_sub_r <= 7'h00;
      end else if (deb_sub_r == US_LAST) begin
         deb_cnt_r <= deb_cnt_r + 20'h00001;
         deb_sub_r <= 7'h00;
      end else begin
         deb_sub_r <= deb_sub_r + 7'h01;
      end
   end

   // Conditioned level per source
   logic cond, cond_q_r, act_evt, is_pin, use_sw, trig_evt;
   always_comb begin
      case (cfg_r.src)
         SRC_LINE0, SRC_LINE2: cond = deb_r;
         SRC_CNT:              cond = counter_i;
         SRC_ANY:              cond = line0_i;
         default:              cond = 1'b0;
      endcase
   end
   always_ff @(posedge aclk) begin
      if (!aresetn)
         cond_q_r <= 1'b0;
      else
         cond_q_r <= cond;
   end

   ctsc_state_t st_r, st_nxt;
   logic        idle;
   assign idle = (st_r == ST_IDLE);
   always_comb begin
      case (cfg_r.act)
         ACT_RISE: act_evt = cond && !cond_q_r;
         ACT_FALL: act_evt = !cond && cond_q_r;
         ACT_HIGH: act_evt = cond && idle;
         ACT_LOW:  act_evt = !cond && idle;
         ACT_ANY:  act_evt = cond != cond_q_r;
         default:  act_evt = 1'b0;
      endcase
   end
   assign is_pin   = (cfg_r.src == SRC_LINE0) || (cfg_r.src == SRC_LINE2);
   assign use_sw   = (cfg_r.src == SRC_SW) || (cfg_r.src == SRC_ANY);
   assign trig_evt = cfg_r.mode && ((act_evt && cfg_r.src != SRC_SW) ||
                                    (sw_pulse_r && use_sw));

   // Burst sequencer
   logic [19:0] ph_cnt_r;
   logic [6:0]  dly_sub_r;
   logic        dly_tick;
   assign dly_tick = (dly_sub_r == US_LAST);
   logic [9:0]  left_r;
   logic [1:0]  q_r;
   logic        q_push, q_pop;
   always_comb begin
      st_nxt = st_r;
      q_pop  = 1'b0;
      case (st_r)
         ST_IDLE:  if (trig_evt || !cfg_r.mode) st_nxt = ST_DELAY;
         ST_DELAY: if (ph_cnt_r >= dly_us_r) st_nxt = ST_EXPO;
         ST_EXPO:  if (ph_cnt_r == EXPO_LAST) st_nxt = ST_READ;
         ST_READ: begin
            if (ph_cnt_r == READ_LAST) begin
               if (left_r > 10'h001) begin
                  st_nxt = ST_EXPO;
               end else if (q_r != 2'h0 && cfg_r.mode) begin
                  st_nxt = ST_DELAY;
                  q_pop  = 1'b1;
               end else begin
                  st_nxt = ST_IDLE;
               end
            end
         end
         default:  st_nxt = ST_IDLE;
      endcase
   end
   // Triggers while busy queue or drop
   assign q_push = trig_evt && !idle && cfg_r.cache && q_r != `CTSC_QDEPTH;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r      <= ST_IDLE;
         ph_cnt_r  <= 20'h00000;
         left_r    <= 10'h000;
         dly_sub_r <= 7'h00;
      end else begin
         st_r <= st_nxt;
         // Delay counts whole microseconds from its own entry, not a free tick
         if (st_nxt != st_r || st_r != ST_DELAY || dly_tick)
            dly_sub_r <= 7'h00;
         else
            dly_sub_r <= dly_sub_r + 7'h01;
         if (st_nxt != st_r)
            ph_cnt_r <= 20'h00000;
         else if (st_r == ST_DELAY ? dly_tick : 1'b1)
            ph_cnt_r <= ph_cnt_r + 20'h00001;
         if (st_r != ST_EXPO && st_r != ST_READ && st_nxt == ST_DELAY)
            left_r <= burst_r;
         else if (st_r == ST_DELAY && st_nxt == ST_DELAY)
            left_r <= burst_r;
         else if (st_r == ST_READ && st_nxt == ST_EXPO)
            left_r <= left_r - 10'h001;
         else if (q_pop)
            left_r <= burst_r;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn || !cfg_r.cache)
         q_r <= 2'h0;
      else if (q_push && !q_pop)
         q_r <= q_r + 2'h1;
      else if (q_pop && !q_push)
         q_r <= q_r - 2'h1;
   end

   // Event sources for the strobe
   logic [12:0] ev;
   always_comb begin
      ev[EV_EXP_ST]    = st_r != ST_EXPO && st_nxt == ST_EXPO;
      ev[EV_EXP_END]   = st_r == ST_EXPO && st_nxt != ST_EXPO;
      ev[EV_ACQ_ST]    = idle && st_nxt != ST_IDLE;
      ev[EV_ACQ_STOP]  = !idle && st_nxt == ST_IDLE;
      ev[EV_BURST_ST]  = st_r == ST_DELAY && st_nxt == ST_EXPO;
      ev[EV_BURST_END] = st_r == ST_READ && st_nxt != ST_READ && st_nxt != ST_EXPO;
      ev[EV_FWAIT]     = idle && cfg_r.mode;
      ev[EV_FRM_ST]    = ev[EV_EXP_ST];
      ev[EV_FRM_END]   = st_r == ST_READ && st_nxt != ST_READ;
      ev[EV_SWTRIG]    = sw_pulse_r && cfg_r.mode && use_sw;
      ev[EV_HWTRIG]    = act_evt && cfg_r.mode && is_pin;
      ev[EV_CNTTRIG]   = act_evt && cfg_r.mode && cfg_r.src == SRC_CNT;
      ev[EV_TIMER]     = timer_i;
   end

   // Strobe pulse; zero length means until exposure ends
   logic        str_on_r, str_lvl, sel_ev, pin_lvl;
   logic [15:0] str_cnt_r;
   assign sel_ev = (cfg_r.ssrc <= EV_TIMER) ? ev[cfg_r.ssrc] : 1'b0;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         str_on_r  <= 1'b0;
         str_cnt_r <= 16'h0000;
      end else if (sel_ev) begin
         str_on_r  <= 1'b1;
         str_cnt_r <= 16'h0000;
      end else if (str_on_r) begin
         if (sdur_r == 16'h0000 ? ev[EV_EXP_END] : str_cnt_r >= sdur_r)
            str_on_r <= 1'b0;
         else if (us_tick)
            str_cnt_r <= str_cnt_r + 16'h0001;
      end
   end
   assign str_lvl = (cfg_r.ssrc == EV_FWAIT) ? ev[EV_FWAIT] : str_on_r;
   assign pin_lvl = (cfg_r.str_en && str_lvl) ^ cfg_r.inv;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         line1_o  <= 1'b0;
         line2_o  <= 1'b0;
         line2_oe <= 1'b0;
         stat_o   <= '0;
      end else begin
         line1_o  <= pin_lvl;
         line2_o  <= pin_lvl;
         line2_oe <= cfg_r.l2_out;
         stat_o   <= '{acquiring: !idle, exposing: st_r == ST_EXPO,
                       frame_wait: ev[EV_FWAIT], queued: q_r};
      end
   end

   // Read channel; unmapped offsets answer SLVERR
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `CTSC_RESP_OK;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rresp   <= `CTSC_RESP_OK;
         case (s_axi_araddr)
            `CTSC_A_CTRL:  s_axi_rdata <= {17'h0, cfg_r.ssrc, cfg_r.l2_out, cfg_r.inv,
                                           cfg_r.str_en, cfg_r.cache, cfg_r.act,
                                           cfg_r.src, cfg_r.mode};
            `CTSC_A_BURST: s_axi_rdata <= {22'h0, burst_r};
            `CTSC_A_DELAY: s_axi_rdata <= {12'h0, dly_us_r};
            `CTSC_A_DEB:   s_axi_rdata <= {12'h0, deb_us_r};
            `CTSC_A_SDUR:  s_axi_rdata <= {16'h0, sdur_r};
            `CTSC_A_SWTRIG: s_axi_rdata <= 32'h0000_0000;
            `CTSC_A_STAT:  s_axi_rdata <= {18'h0, left_r, q_r, ev[EV_FWAIT],
                                           !idle};
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= `CTSC_RESP_ERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   property p_burst_range;
      @(posedge aclk) disable iff (!aresetn)
      burst_r >= `CTSC_BURST_MIN && burst_r <= `CTSC_BURST_MAX;
   endproperty
   a_burst_range: assert property (p_burst_range) else $error("burst out of range");

   property p_burst_end;
      @(posedge aclk) disable iff (!aresetn)
      (st_r == ST_READ && ph_cnt_r == READ_LAST && left_r == 10'h001 && q_r == 2'h0)
      |=> st_r == ST_IDLE;
   endproperty
   a_burst_end: assert property (p_burst_end) else $error("burst did not stop");

   property p_next_frame;
      @(posedge aclk) disable iff (!aresetn)
      (st_r == ST_READ && ph_cnt_r == READ_LAST && left_r > 10'h001)
      |=> st_r == ST_EXPO && left_r == $past(left_r) - 10'h001;
   endproperty
   a_next_frame: assert property (p_next_frame) else $error("frame count wrong");

   property p_q_max;
      @(posedge aclk) disable iff (!aresetn)
      (trig_evt && !idle && cfg_r.cache && !q_pop)
      |=> q_r == (($past(q_r) == `CTSC_QDEPTH) ? `CTSC_QDEPTH : $past(q_r) + 2'h1);
   endproperty
   a_q_max: assert property (p_q_max) else $error("queue over three");

   property p_drop;
      @(posedge aclk) disable iff (!aresetn)
      !cfg_r.cache |=> q_r == 2'h0;
   endproperty
   a_drop: assert property (p_drop) else $error("trigger kept without queue");

   property p_inv_reset;
      @(posedge aclk) !aresetn |=> !cfg_r.inv ##1 line1_o == 1'b0;
   endproperty
   a_inv_reset: assert property (p_inv_reset) else $error("inversion on after reset");

   property p_sw_start;
      @(posedge aclk) disable iff (!aresetn)
      (idle && cfg_r.mode && cfg_r.src == SRC_SW && sw_pulse_r) |=> st_r == ST_DELAY;
   endproperty
   a_sw_start: assert property (p_sw_start) else $error("software trigger lost");

   property p_dir;
      @(posedge aclk) disable iff (!aresetn)
      $changed(cfg_r.l2_out) |=> line2_oe == $past(cfg_r.l2_out);
   endproperty
   a_dir: assert property (p_dir) else $error("line 2 direction wrong");

   property p_strobe_expo;
      @(posedge aclk) disable iff (!aresetn)
      (cfg_r.str_en && !cfg_r.inv && sdur_r == 16'h0000 && cfg_r.ssrc == EV_EXP_ST
       && ev[EV_EXP_ST]) |=> ##1 line1_o;
   endproperty
   a_strobe_expo: assert property (p_strobe_expo) else $error("strobe missing");
endmodule : ctsc_trigger

// ---- ctsc_ext_model.sv ----
// External trigger sources and strobe load seen from the camera pins
`timescale 1ns/1ps
module ctsc_ext_model (
   input  wire logic aclk,
   input  wire logic line2_o,
   input  wire logic line2_oe,
   output logic      line0_i,
   output logic      line2_i,
   output logic      counter_i,
   output logic      timer_i
);
   logic [3:0] drv_r = 4'h0;
   assign line0_i   = drv_r[0];
   // Shared pin: the camera side wins while it holds the enable
   assign line2_i   = line2_oe ? line2_o : drv_r[1];
   assign counter_i = drv_r[2];
   assign timer_i   = drv_r[3];
   // Levels change just after an edge so the camera sees a whole cycle
   task automatic put(input int idx, input logic v);
      @(posedge aclk);
      drv_r[idx] <= v;
   endtask : put
endmodule : ctsc_ext_model

// ---- tb_top.sv ----
// Self-checking bench for the trigger and strobe block
`timescale 1ns/1ps
`include "ctsc_consts.svh"
module tb_top;
   import ctsc_pkg::*;
   logic        aclk = 1'h0;
   logic        aresetn = 1'h0;
   logic [7:0]  s_axi_awaddr = 8'h00;
   logic [7:0]  s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0]  s_axi_wstrb = `CTSC_FULL_STRB;
   logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp, r;
   logic [31:0] s_axi_rdata, d;
   logic        line0_i, line2_i, counter_i, timer_i, line1_o, line2_o, line2_oe;
   logic        exp_q = 1'h0;
   ctsc_stat_t  stat_o;
   int          n_errors = 0, check_count = 0, frames = 0, hi = 0, f0, k;

   always #5 aclk = ~aclk;
   // Exposure starts and strobe-high cycles are the yardsticks
   always @(posedge aclk) begin
      exp_q <= stat_o.exposing;
      frames <= frames + int'(stat_o.exposing && !exp_q);
      hi <= hi + int'(line1_o);
   end

   ctsc_trigger #(.EXPO_CYC(4), .READ_CYC(4)) ctsc_trigger_inst (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .line0_i, .line2_i, .counter_i,
      .timer_i, .line1_o, .line2_o, .line2_oe, .stat_o);
   ctsc_ext_model ctsc_ext_model_inst (
      .aclk, .line2_o, .line2_oe, .line0_i, .line2_i, .counter_i, .timer_i);

   task automatic conclude;
      if (n_errors == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : conclude

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic hang;
      n_errors++;
      conclude();
   endtask : hang

   // One bus transfer; holds every channel until its own handshake
   task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] v);
      int t;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_araddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= w;
      s_axi_wvalid <= w;
      s_axi_bready <= w;
      s_axi_arvalid <= !w;
      s_axi_rready <= !w;
      for (t = 0; t < 50 && !(s_axi_bvalid && w) && !(s_axi_rvalid && !w); t++) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end
      d = s_axi_rdata;
      r = w ? s_axi_bresp : s_axi_rresp;
      s_axi_bready <= 1'h0;
      s_axi_rready <= 1'h0;
      if (t == 50) hang();
   endtask : xf

   // Idle must last longer than the worst filter tick before it counts
   task automatic wait_idle;
      int q;
      int t;
      q = 0;
      for (t = 0; t < 12000 && q < 400; t++) begin
         @(posedge aclk);
         q = stat_o.acquiring === 1'h1 ? 0 : q + 1;
      end
      if (q < 400) hang();
   endtask : wait_idle

   task automatic fire(input int pin, input int w);
      if (pin < 0) xf(1'h1, `CTSC_A_SWTRIG, 32'h1);
      else begin
         ctsc_ext_model_inst.put(pin, 1'h1);
         repeat (w) @(posedge aclk);
         ctsc_ext_model_inst.put(pin, 1'h0);
      end
   endtask : fire

   task automatic cfg(input logic [31:0] c);
      xf(1'h1, `CTSC_A_CTRL, c);
      wait_idle();
   endtask : cfg

   task automatic run(input int pin, input int w, input int reps, input int n);
      f0 = frames;
      repeat (reps) fire(pin, w);
      wait_idle();
      check(frames - f0, n);
   endtask : run

   function automatic logic [31:0] ctl(ctsc_src_t s, ctsc_act_t a, logic [7:0] x);
      return {17'h0, x, a, s, 1'h1};
   endfunction : ctl

   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'h1;
      xf(1'h0, `CTSC_A_CTRL, 32'h0);
      check(d, 32'h0);
      xf(1'h0, `CTSC_A_BURST, 32'h0);
      check(d, 32'h1);
      repeat (20) @(posedge aclk);
      check(32'(stat_o.acquiring), 32'h1);
      xf(1'h1, `CTSC_A_BURST, 32'h0);
      xf(1'h1, `CTSC_A_BURST, 32'h400);
      xf(1'h0, `CTSC_A_BURST, 32'h0);
      check(d, 32'h1);
      xf(1'h1, `CTSC_A_BURST, 32'h3FF);
      check({30'h0, r}, {30'h0, `CTSC_RESP_OK});
      xf(1'h0, `CTSC_A_BURST, 32'h0);
      check(d, 32'h3FF);
      xf(1'h1, `CTSC_A_DEB, 32'hF4240);
      xf(1'h1, `CTSC_A_DEB, 32'hF4241);
      xf(1'h0, `CTSC_A_DEB, 32'h0);
      check(d, 32'hF4240);
      xf(1'h0, 8'h1C, 32'h0);
      check({30'h0, r}, {30'h0, `CTSC_RESP_ERR});
      xf(1'h1, 8'h1C, 32'h0);
      check({30'h0, r}, {30'h0, `CTSC_RESP_ERR});
      xf(1'h1, `CTSC_A_DEB, 32'h0);
      xf(1'h1, `CTSC_A_BURST, 32'h1);
      cfg(ctl(SRC_SW, ACT_RISE, 8'h00));
      check(32'(stat_o.frame_wait), 32'h1);
      run(-1, 0, 1, 1);
      xf(1'h1, `CTSC_A_BURST, 32'h8);
      run(-1, 0, 1, 8);
      run(-1, 0, 2, 8);
      cfg(ctl(SRC_SW, ACT_RISE, 8'h01));
      f0 = frames;
      repeat (5) fire(-1, 0);
      check(32'(stat_o.queued), 32'h3);
      wait_idle();
      check(frames - f0, 32);
      xf(1'h1, `CTSC_A_DELAY, 32'h1);
      fire(-1, 0);
      for (k = 0; k < 300 && stat_o.exposing !== 1'h1; k++) @(posedge aclk);
      check(32'(k >= 99 && k <= 106), 32'h1);
      wait_idle();
      xf(1'h1, `CTSC_A_DELAY, 32'h0);
      for (k = 0; k < 3; k++) begin
         cfg(ctl(SRC_LINE0, ctsc_act_t'(k == 2 ? 4 : k), 8'h00));
         run(0, 150, 1, k == 2 ? 16 : 8);
      end
      for (k = 0; k < 2; k++) begin
         ctsc_ext_model_inst.put(0, k[0]);
         cfg(ctl(SRC_LINE0, ctsc_act_t'(2 + k), 8'h00));
         f0 = frames;
         fire(0, 0);
         ctsc_ext_model_inst.put(0, !k[0]);
         repeat (300) @(posedge aclk);
         ctsc_ext_model_inst.put(0, k[0]);
         wait_idle();
         check(32'(frames - f0 > 8), 32'h1);
      end
      ctsc_ext_model_inst.put(0, 1'h0);
      xf(1'h1, `CTSC_A_DEB, 32'h2);
      cfg(ctl(SRC_LINE0, ACT_RISE, 8'h00));
      run(0, 100, 1, 0);
      run(0, 400, 1, 8);
      cfg(ctl(SRC_LINE2, ACT_RISE, 8'h00));
      run(1, 400, 1, 8);
      for (k = 0; k < 3; k++) begin
         cfg(ctl(k == 0 ? SRC_CNT : k == 1 ? SRC_SW : SRC_ANY, ctsc_act_t'(k == 1), 8'h00));
         run(k == 0 ? 2 : -1, 20, 1, 8);
      end
      xf(1'h1, `CTSC_A_DEB, 32'h0);
      xf(1'h1, `CTSC_A_BURST, 32'h1);
      cfg(ctl(SRC_SW, ACT_RISE, {EV_EXP_ST, 4'hA}));
      check(32'(line2_oe), 32'h1);
      f0 = hi;
      fire(-1, 0);
      wait_idle();
      check(hi - f0, 32'h4);
      cfg(ctl(SRC_SW, ACT_RISE, {EV_EXP_ST, 4'h6}));
      check(32'(line1_o), 32'h1);
      check(32'(line2_o), 32'h1);
      check(32'(line2_oe), 32'h0);
      xf(1'h1, `CTSC_A_SDUR, 32'h1);
      for (k = 0; k < 13; k++) begin
         cfg(ctl(k == 10 ? SRC_LINE0 : k == 11 ? SRC_CNT : SRC_SW, ACT_RISE, {k[3:0], 4'h2}));
         f0 = hi;
         fire(k == 10 ? 0 : k == 11 ? 2 : k == 12 ? 3 : -1, 150);
         wait_idle();
         check(32'(hi > f0), 32'h1);
      end
      conclude();
   end
endmodule : tb_top
